// file: logic/ixs_core.sv
// execution core for a subset of an 8-bit microcontroller instruction set.
// assumes an Avalon-MM master that holds each request until waitrequest is low.
//
// Function
// - indexed jump loads table-high-pointer bits 2:0 into pc bits 10:8.
// - indexed jump loads accumulator into pc 7:0; takes two cycles.
// - increment-skip adds one; dest bit 0 to accumulator, 1 to register.
// - zero increment result discards the fetched next instruction, runs no-op.
// - increment-skip takes one cycle, or two when it skips.
// - software interrupt pushes pc plus one onto the return stack top.
// - software interrupt then loads vector 0x001 into pc; three cycles, flags untouched.
// - or-immediate ors accumulator with immediate, updates zero, one cycle.
// - or-register ors accumulator with register, updates zero, dest bit selects.
// - upper-page write copies accumulator to special register 5..15, no flags.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module ixs_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	// ****************************************
	// state
	// ****************************************
	ixs_pkg::ixs_state_t state_reg;
	logic [1:0] cnt_reg;
	logic ack_reg;
	logic [ixs_pkg::CMD_W-1:0] cmd_reg;
	logic [7:0] acc_reg;
	logic [7:0] table_high_pointer_reg;
	logic [10:0] pc_reg;
	logic zero_reg;
	logic [10:0] stack_reg;
	logic [6:0] file_sel_reg;
	logic [3:0] upg_sel_reg;
	logic [7:0] file_mem [ixs_pkg::FILE_DEPTH];
	logic [7:0] upg_mem [ixs_pkg::UPG_DEPTH];

	// ****************************************
	// decode
	// ****************************************
	logic idle_req;
	logic bus_wr;
	logic bus_rd;
	logic cmd_start;
	logic exec_done;
	logic ack_next;
	logic [2:0] op;
	logic [7:0] opnd;
	logic dest;
	logic [7:0] file_val;
	logic [7:0] inc_res;
	logic [7:0] or_res;
	logic [7:0] or_imm_res;
	logic [2:0] new_op;
	logic [7:0] new_file_val;
	logic [1:0] new_cycles;
	logic upg_ok;

	// a request is only taken while idle and not in its own ack cycle
	assign idle_req = (state_reg == ixs_pkg::IXS_IDLE) && !ack_reg;
	assign bus_wr = idle_req && avs_write_i;
	assign bus_rd = idle_req && avs_read_i && !avs_write_i;
	assign cmd_start = bus_wr && (avs_address_i == ixs_pkg::ADDR_CMD);
	assign exec_done = (state_reg == ixs_pkg::IXS_EXEC) && (cnt_reg == 2'h0);
	assign ack_next = exec_done || (bus_wr && !cmd_start) || bus_rd;

	// fields of the running command
	assign op = cmd_reg[ixs_pkg::CMD_OP_LSB +: ixs_pkg::CMD_OP_W];
	assign opnd = cmd_reg[ixs_pkg::CMD_OPND_LSB +: ixs_pkg::CMD_OPND_W];
	assign dest = cmd_reg[ixs_pkg::CMD_DEST_BIT];
	assign file_val = file_mem[opnd[6:0]];
	assign inc_res = file_val + 8'h01;
	assign or_res = acc_reg | file_val;
	assign or_imm_res = acc_reg | opnd;
	assign upg_ok = (opnd[7:4] == 4'h0) && (opnd[3:0] >= ixs_pkg::UPG_LOW)
		&& (opnd[3:0] <= ixs_pkg::UPG_HIGH);

	// cycle count of the incoming command, known before it starts
	assign new_op = avs_writedata_i[ixs_pkg::CMD_OP_LSB +: ixs_pkg::CMD_OP_W];
	assign new_file_val = file_mem[avs_writedata_i[6:0]];
	always_comb begin
		new_cycles = ixs_pkg::CYC_ONE;
		if (new_op == ixs_pkg::OP_ACC_JUMP) begin
			new_cycles = ixs_pkg::CYC_TWO;
		end else if (new_op == ixs_pkg::OP_SW_INT) begin
			new_cycles = ixs_pkg::CYC_THREE;
		end else if (new_op == ixs_pkg::OP_INC_SKIP && new_file_val == 8'hff) begin
			new_cycles = ixs_pkg::CYC_TWO;
		end
	end

	// ****************************************
	// sequencer and bus handshake
	// ****************************************
	// command runs hold waitrequest for the whole execution time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ixs_pkg::IXS_IDLE;
			cnt_reg <= 2'h0;
			cmd_reg <= '0;
		end else if (cmd_start) begin
			state_reg <= ixs_pkg::IXS_EXEC;
			cnt_reg <= new_cycles - 2'h1;
			cmd_reg <= avs_writedata_i[ixs_pkg::CMD_W-1:0];
		end else if (exec_done) begin
			state_reg <= ixs_pkg::IXS_IDLE;
		end else if (state_reg == ixs_pkg::IXS_EXEC) begin
			cnt_reg <= cnt_reg - 2'h1;
		end
	end

	// one-cycle ack, waitrequest registered as its inverse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			ack_reg <= ack_next;
			avs_waitrequest_o <= !ack_next;
		end
	end

	// read data registered with the ack; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= ixs_pkg::READ_UNMAPPED;
		end else if (bus_rd) begin
			unique case (avs_address_i)
				ixs_pkg::ADDR_CMD: avs_readdata_o <= {20'h0, cmd_reg};
				ixs_pkg::ADDR_ACC: avs_readdata_o <= {24'h0, acc_reg};
				ixs_pkg::ADDR_TABLE_HIGH_POINTER: avs_readdata_o <= {24'h0, table_high_pointer_reg};
				ixs_pkg::ADDR_PC: avs_readdata_o <= {21'h0, pc_reg};
				ixs_pkg::ADDR_STATUS: avs_readdata_o <= {31'h0, zero_reg};
				ixs_pkg::ADDR_STACK: avs_readdata_o <= {21'h0, stack_reg};
				ixs_pkg::ADDR_FILE_SEL: avs_readdata_o <= {25'h0, file_sel_reg};
				ixs_pkg::ADDR_FILE_DATA: avs_readdata_o <= {24'h0, file_mem[file_sel_reg]};
				ixs_pkg::ADDR_UPG_SEL: avs_readdata_o <= {28'h0, upg_sel_reg};
				ixs_pkg::ADDR_UPG_DATA: avs_readdata_o <= {24'h0, upg_mem[upg_sel_reg]};
				default: avs_readdata_o <= ixs_pkg::READ_UNMAPPED;
			endcase
		end
	end

	// ****************************************
	// architectural registers
	// ****************************************
	// accumulator: bus load or instruction result
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= ixs_pkg::BYTE_RESET;
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_ACC) begin
			acc_reg <= avs_writedata_i[7:0];
		end else if (exec_done) begin
			if (op == ixs_pkg::OP_INC_SKIP && !dest) begin
				acc_reg <= inc_res;
			end else if (op == ixs_pkg::OP_OR_IMM) begin
				acc_reg <= or_imm_res;
			end else if (op == ixs_pkg::OP_OR_REG && !dest) begin
				acc_reg <= or_res;
			end
		end
	end

	// table high pointer is software-loaded only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			table_high_pointer_reg <= ixs_pkg::BYTE_RESET;
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_TABLE_HIGH_POINTER) begin
			table_high_pointer_reg <= avs_writedata_i[7:0];
		end
	end

	// program counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg <= ixs_pkg::PC_RESET;
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_PC) begin
			pc_reg <= avs_writedata_i[10:0];
		end else if (exec_done) begin
			if (op == ixs_pkg::OP_ACC_JUMP) begin
				pc_reg <= {table_high_pointer_reg[2:0], acc_reg};
			end else if (op == ixs_pkg::OP_SW_INT) begin
				pc_reg <= ixs_pkg::SW_INT_VECTOR;
			end else if (op == ixs_pkg::OP_INC_SKIP && inc_res == 8'h00) begin
				pc_reg <= pc_reg + 11'h002;
			end else begin
				pc_reg <= pc_reg + 11'h001;
			end
		end
	end

	// zero flag; jump, interrupt and upper-page write leave it alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_reg <= 1'b0;
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_STATUS) begin
			zero_reg <= avs_writedata_i[ixs_pkg::STATUS_ZERO_BIT];
		end else if (exec_done) begin
			if (op == ixs_pkg::OP_INC_SKIP) begin
				zero_reg <= (inc_res == 8'h00);
			end else if (op == ixs_pkg::OP_OR_IMM) begin
				zero_reg <= (or_imm_res == 8'h00);
			end else if (op == ixs_pkg::OP_OR_REG) begin
				zero_reg <= (or_res == 8'h00);
			end
		end
	end

	// single top-of-stack entry; depth handling lives elsewhere
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stack_reg <= ixs_pkg::PC_RESET;
		end else if (exec_done && op == ixs_pkg::OP_SW_INT) begin
			stack_reg <= pc_reg + 11'h001;
		end
	end

	// window selectors into file and upper page
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			file_sel_reg <= 7'h00;
			upg_sel_reg <= 4'h0;
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_FILE_SEL) begin
			file_sel_reg <= avs_writedata_i[6:0];
		end else if (bus_wr && avs_address_i == ixs_pkg::ADDR_UPG_SEL) begin
			upg_sel_reg <= avs_writedata_i[3:0];
		end
	end

	// ****************************************
	// memories
	// ****************************************
	// register file: no reset, contents undefined until written
	always_ff @(posedge clk_i) begin
		if (bus_wr && avs_address_i == ixs_pkg::ADDR_FILE_DATA) begin
			file_mem[file_sel_reg] <= avs_writedata_i[7:0];
		end else if (exec_done && dest && op == ixs_pkg::OP_INC_SKIP) begin
			file_mem[opnd[6:0]] <= inc_res;
		end else if (exec_done && dest && op == ixs_pkg::OP_OR_REG) begin
			file_mem[opnd[6:0]] <= or_res;
		end
	end

	// upper page; out-of-range instruction operands are dropped silently, bus writes reach all 16 slots
	always_ff @(posedge clk_i) begin
		if (bus_wr && avs_address_i == ixs_pkg::ADDR_UPG_DATA) begin
			upg_mem[upg_sel_reg] <= avs_writedata_i[7:0];
		end else if (exec_done && op == ixs_pkg::OP_UPG_WRITE && upg_ok) begin
			upg_mem[opnd[3:0]] <= acc_reg;
		end
	end
endmodule

// file: logic/ixs_pkg.sv
// package for the instruction execution subset: register map, command fields,
// operation codes, cycle counts and reset values.
// assumes word-indexed Avalon-MM addressing (byte address = 4 * index).
package ixs_pkg;
	// ****************************************
	// register map, word indices
	// ****************************************
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_ACC = 4'h1;
	localparam logic [3:0] ADDR_TABLE_HIGH_POINTER = 4'h2;
	localparam logic [3:0] ADDR_PC = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_STACK = 4'h5;
	localparam logic [3:0] ADDR_FILE_SEL = 4'h6;
	localparam logic [3:0] ADDR_FILE_DATA = 4'h7;
	localparam logic [3:0] ADDR_UPG_SEL = 4'h8;
	localparam logic [3:0] ADDR_UPG_DATA = 4'h9;

	// ****************************************
	// command word fields
	// ****************************************
	localparam int CMD_OPND_LSB = 0;
	localparam int CMD_OPND_W = 8;
	localparam int CMD_DEST_BIT = 8;
	localparam int CMD_OP_LSB = 9;
	localparam int CMD_OP_W = 3;
	localparam int CMD_W = 12;
	localparam int STATUS_ZERO_BIT = 0;

	// ****************************************
	// operation codes
	// ****************************************
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_ACC_JUMP = 3'h1;
	localparam logic [2:0] OP_INC_SKIP = 3'h2;
	localparam logic [2:0] OP_SW_INT = 3'h3;
	localparam logic [2:0] OP_OR_IMM = 3'h4;
	localparam logic [2:0] OP_OR_REG = 3'h5;
	localparam logic [2:0] OP_UPG_WRITE = 3'h6;

	// ****************************************
	// cycle counts, widths, constants
	// ****************************************
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam int PC_W = 11;
	localparam int FILE_DEPTH = 128;
	localparam int UPG_DEPTH = 16;
	localparam logic [3:0] UPG_LOW = 4'h5;
	localparam logic [3:0] UPG_HIGH = 4'hf;
	localparam logic [10:0] SW_INT_VECTOR = 11'h001;
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

	typedef enum logic {IXS_IDLE, IXS_EXEC} ixs_state_t;
endpackage

// file: verif/ixs_core_test.sv
// self-checking bench for the execution core, driven over its register bus.
// assumes the register map and command encoding of ixs_pkg.
`timescale 1ns/1ns
module ixs_core_test;
	// ****************************************
	// signals, tasks and test sequence
	// ****************************************
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	int n_errors = 0;
	int checks_done = 0;
	int f[3] = '{4, 5, 15};
	always #20 clk_i = ~clk_i;
	ixs_core dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one transfer; waits an edge first so no signal is driven twice in a step
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output int n);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		n = 0;
		do @(posedge clk_i) n++; while (avs_waitrequest_o !== 1'b0 && n < 50);
		// a hung handshake ends the run at the common closing point
		if (n >= 50) begin
			n_errors++;
			$display("MISMATCH t=%0t bus answer timed out", $time);
			give_verdict();
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic w(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		int n;
		bus(a, 1'b1, d, q, n);
	endtask
	task automatic r(input logic [3:0] a, input logic [31:0] exp);
		logic [31:0] q;
		int n;
		bus(a, 1'b0, 32'h0, q, n);
		chk(q, exp);
	endtask
	// command; edges to ack are the instruction cycles plus two
	task automatic x(input logic [2:0] op, input logic dst, input logic [7:0] v, input int cyc);
		logic [31:0] q;
		int n;
		bus(ixs_pkg::ADDR_CMD, 1'b1, {20'h0, op, dst, v}, q, n);
		chk(32'(n), 32'(cyc + 2));
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(40 * 5000);
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		r(ixs_pkg::ADDR_PC, 32'h0);
		w(ixs_pkg::ADDR_TABLE_HIGH_POINTER, 32'hfd);
		w(ixs_pkg::ADDR_ACC, 32'h3c);
		x(ixs_pkg::OP_ACC_JUMP, 1'b0, 8'h00, 2);
		r(ixs_pkg::ADDR_PC, 32'h53c);
		$display("test jump done");
		w(ixs_pkg::ADDR_STATUS, 32'h1);
		x(ixs_pkg::OP_SW_INT, 1'b0, 8'h00, 3);
		r(ixs_pkg::ADDR_STACK, 32'h53d);
		r(ixs_pkg::ADDR_PC, 32'h001);
		r(ixs_pkg::ADDR_STATUS, 32'h1);
		$display("test interrupt done");
		w(ixs_pkg::ADDR_FILE_SEL, 32'h7f);
		w(ixs_pkg::ADDR_FILE_DATA, 32'h41);
		x(ixs_pkg::OP_INC_SKIP, 1'b1, 8'h7f, 1);
		r(ixs_pkg::ADDR_FILE_DATA, 32'h42);
		r(ixs_pkg::ADDR_STATUS, 32'h0);
		r(ixs_pkg::ADDR_PC, 32'h002);
		w(ixs_pkg::ADDR_FILE_DATA, 32'hff);
		x(ixs_pkg::OP_INC_SKIP, 1'b0, 8'h7f, 2);
		r(ixs_pkg::ADDR_ACC, 32'h0);
		r(ixs_pkg::ADDR_FILE_DATA, 32'hff);
		r(ixs_pkg::ADDR_PC, 32'h004);
		r(ixs_pkg::ADDR_STATUS, 32'h1);
		$display("test increment done");
		w(ixs_pkg::ADDR_ACC, 32'haa);
		x(ixs_pkg::OP_OR_IMM, 1'b0, 8'h50, 1);
		r(ixs_pkg::ADDR_ACC, 32'hfa);
		r(ixs_pkg::ADDR_STATUS, 32'h0);
		w(ixs_pkg::ADDR_ACC, 32'h0);
		x(ixs_pkg::OP_OR_IMM, 1'b0, 8'h00, 1);
		r(ixs_pkg::ADDR_STATUS, 32'h1);
		w(ixs_pkg::ADDR_FILE_DATA, 32'h50);
		w(ixs_pkg::ADDR_ACC, 32'haa);
		x(ixs_pkg::OP_OR_REG, 1'b1, 8'h7f, 1);
		r(ixs_pkg::ADDR_FILE_DATA, 32'hfa);
		r(ixs_pkg::ADDR_ACC, 32'haa);
		r(ixs_pkg::ADDR_STATUS, 32'h0);
		w(ixs_pkg::ADDR_FILE_DATA, 32'h05);
		x(ixs_pkg::OP_OR_REG, 1'b0, 8'h7f, 1);
		r(ixs_pkg::ADDR_ACC, 32'haf);
		$display("test or done");
		w(ixs_pkg::ADDR_ACC, 32'h5a);
		w(ixs_pkg::ADDR_STATUS, 32'h1);
		w(ixs_pkg::ADDR_UPG_SEL, 32'h4);
		w(ixs_pkg::ADDR_UPG_DATA, 32'h11);
		// f of 4 lies below the page and must leave its slot alone
		foreach (f[i]) begin
			x(ixs_pkg::OP_UPG_WRITE, 1'b0, 8'(f[i]), 1);
			w(ixs_pkg::ADDR_UPG_SEL, 32'(f[i]));
			r(ixs_pkg::ADDR_UPG_DATA, (f[i] == 4) ? 32'h11 : 32'h5a);
		end
		r(ixs_pkg::ADDR_STATUS, 32'h1);
		w(4'hc, 32'hff);
		r(4'hc, 32'h0);
		$display("test upper page done");
		// spare opcode acts as no-op: pc steps, file and flag untouched
		x(3'h7, 1'b1, 8'h7f, 1);
		r(ixs_pkg::ADDR_PC, 32'h00c);
		r(ixs_pkg::ADDR_FILE_DATA, 32'h05);
		r(ixs_pkg::ADDR_STATUS, 32'h1);
		r(ixs_pkg::ADDR_CMD, 32'hf7f);
		x(ixs_pkg::OP_NOP, 1'b0, 8'h00, 1);
		r(ixs_pkg::ADDR_PC, 32'h00d);
		r(ixs_pkg::ADDR_ACC, 32'h5a);
		$display("test no-op done");
		give_verdict();
	end
endmodule

// file: verif/ixs_monitor.sv
// checker for the execution core: bus answer timing and read-back widths.
// assumes an Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/1ns
module ixs_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o
);
	// ****************************************
	// helper logic and properties
	// ****************************************
	logic out_reg;
	logic new_req;
	logic cmd_new;
	logic rd_new;
	logic [2:0] op;
	// a request still waiting from last cycle is not a new one
	always_ff @(posedge clk_i) begin
		out_reg <= !rst_i && (avs_read_i || avs_write_i) && avs_waitrequest_o;
	end
	assign new_req = (avs_read_i || avs_write_i) && !out_reg;
	assign cmd_new = new_req && avs_write_i && avs_address_i == ixs_pkg::ADDR_CMD;
	assign rd_new = new_req && avs_read_i && !avs_write_i;
	assign op = avs_writedata_i[ixs_pkg::CMD_OP_LSB +: 3];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_busy1;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	sequence s_busy2;
		avs_waitrequest_o [*2] ##1 !avs_waitrequest_o;
	endsequence
	sequence s_busy3;
		avs_waitrequest_o [*3] ##1 !avs_waitrequest_o;
	endsequence
	a_jump_two_cyc: assert property (cmd_new && op == ixs_pkg::OP_ACC_JUMP |=> s_busy2)
		else $error("indexed jump not two cycles");
	a_int_three_cyc: assert property (cmd_new && op == ixs_pkg::OP_SW_INT |=> s_busy3)
		else $error("software interrupt not three cycles");
	a_or_upg_one: assert property (cmd_new && (op == ixs_pkg::OP_OR_IMM
		|| op == ixs_pkg::OP_OR_REG || op == ixs_pkg::OP_UPG_WRITE) |=> s_busy1)
		else $error("single cycle op took other length");
	a_inc_skip_len: assert property (cmd_new && op == ixs_pkg::OP_INC_SKIP
		|=> s_busy1 or s_busy2)
		else $error("increment skip length wrong");
	a_read_ack_next: assert property (rd_new |=> !avs_waitrequest_o)
		else $error("read not answered next cycle");
	a_pc_width: assert property (rd_new && avs_address_i == ixs_pkg::ADDR_PC
		|=> avs_readdata_o[31:11] == 21'h0)
		else $error("pc wider than eleven bits");
	a_zero_flag_bit: assert property (rd_new && avs_address_i == ixs_pkg::ADDR_STATUS
		|=> avs_readdata_o[31:1] == 31'h0)
		else $error("status upper bits set");
	a_ack_one_cyc: assert property (!avs_waitrequest_o
		|-> (avs_read_i || avs_write_i) ##1 avs_waitrequest_o)
		else $error("ack not a single cycle with request");
endmodule
bind ixs_core ixs_monitor u_mon (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);
